// File: common/ssl_mem_if.sv
// Port bundle between the controller and the storage array.
`timescale 1ns/1ps
interface ssl_mem_if #(
    parameter int AW = ssl_pkg::ADDR_W,
    parameter int DW = ssl_pkg::DATA_W,
    parameter int LN = ssl_pkg::DATA_W / ssl_pkg::LANE_W
);
    logic          we;        // Commit the buffered write this edge.
    logic [AW-1:0] waddr;     // Array address of the commit, bank bit on top.
    logic [DW-1:0] wdata;     // Data of the commit.
    logic [LN-1:0] wmask;     // Lanes written by the commit, active high.
    logic          re;        // Load the read register this edge.
    logic [AW-1:0] raddr;     // Array address of the read, bank bit on top.
    logic          hit;       // The read matches the buffered write.
    logic [DW-1:0] byp_data;  // Buffered write data for the merge.
    logic [LN-1:0] byp_mask;  // Lanes of the buffered write for the merge.
    logic [DW-1:0] rdata;     // Registered read data.

    // Controller side drives requests and sees read data.
    modport ctrl (output we, waddr, wdata, wmask, re, raddr, hit, byp_data, byp_mask,
                  input rdata);
    // Array side takes requests and returns read data.
    modport mem (input we, waddr, wdata, wmask, re, raddr, hit, byp_data, byp_mask,
                 output rdata);
endinterface : ssl_mem_if

// File: common/ssl_pkg.sv
// Shared constants for the synchronous late-write static RAM.
package ssl_pkg;

    // Word width of the wide organisation, in bits.
    localparam int DATA_W = 36;
    // Address width of the wide organisation, including the bank-select pin.
    localparam int ADDR_W = 19;
    // Width of one byte lane, including its parity-style ninth bit.
    localparam int LANE_W = 9;

    // Level of the bank mode strap that selects the two-bank scheme.
    localparam logic MODE_BANK_LEVEL = 1'b0;
    // Value of every control flop after reset.
    localparam logic CTRL_RST = 1'b0;
    // Value of the strap synchroniser after reset: conventional operation.
    localparam logic [1:0] STRAP_RST = 2'h3;
    // Number of flops in the strap synchroniser.
    localparam int SYNC_STAGES = 2;

endpackage : ssl_pkg

// File: logic/ssl_mem.sv
// Storage array with one commit port and a registered, merging read port.
`timescale 1ns/1ps
module ssl_mem #(
    parameter int AW = ssl_pkg::ADDR_W,
    parameter int DW = ssl_pkg::DATA_W,
    parameter int LN = ssl_pkg::DATA_W / ssl_pkg::LANE_W
) (
    input  wire logic mclk,
    ssl_mem_if.mem    mp
);
    // Widens a lane mask to one bit per data bit.
    function automatic logic [DW-1:0] lane_bits(input logic [LN-1:0] m);
        logic [DW-1:0] r;
        r = '0;
        for (int i = 0; i < LN; i++) begin
            r[i*ssl_pkg::LANE_W +: ssl_pkg::LANE_W] = {ssl_pkg::LANE_W{m[i]}};
        end
        return r;
    endfunction

    logic [DW-1:0] array_q [0:(2**AW)-1]; // The cells; contents survive reset.
    logic [DW-1:0] rd_q;                  // Read register.
    logic [DW-1:0] wbits;                 // Written bits of the commit.
    logic [DW-1:0] bbits;                 // Bits taken from the write buffer.

    assign wbits = lane_bits(mp.wmask);
    assign bbits = mp.hit ? lane_bits(mp.byp_mask) : '0;

    // Commits only the enabled lanes and keeps the others.
    always_ff @(posedge mclk) begin
        if (mp.we) begin
            array_q[mp.waddr] <= (array_q[mp.waddr] & ~wbits) | (mp.wdata & wbits);
        end
    end

    // Reads the cell, letting buffered lanes override it so data stay coherent.
    always_ff @(posedge mclk) begin
        if (mp.re) begin
            rd_q <= (array_q[mp.raddr] & ~bbits) | (mp.byp_data & bbits);
        end
    end

    assign mp.rdata = rd_q;
endmodule : ssl_mem // ssl_mem

// File: logic/ssl_sync.sv
// Two-flop synchroniser for a static strap level.
`timescale 1ns/1ps
module ssl_sync (
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic async_in,
    output logic      sync_out
);
    // All state of the synchroniser.
    typedef struct packed {
        logic [ssl_pkg::SYNC_STAGES-1:0] stage;  // Flop chain, index 0 first.
    } ssl_sync_state_t;

    ssl_sync_state_t st_r;   // Registered state.
    ssl_sync_state_t st_nxt; // Next state.

    // The first flop feeds only the second one.
    always_comb begin
        st_nxt.stage = {st_r.stage[0], async_in};
    end

    // Registers the chain; reset assumes conventional operation.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r.stage <= ssl_pkg::STRAP_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stage[ssl_pkg::SYNC_STAGES-1];
endmodule : ssl_sync // ssl_sync

// File: logic/ssl_top.sv
// Synchronous pipelined static RAM with late writes and a two-bank mode.
`timescale 1ns/1ps
module ssl_top #(
    parameter int DATA_W = ssl_pkg::DATA_W,   // Word width, 36 or 18.
    parameter int ADDR_W = ssl_pkg::ADDR_W,   // Address width, 19 or 20.
    parameter int LANES  = DATA_W / ssl_pkg::LANE_W
) (
    input  wire logic              mclk,
    input  wire logic              nrst,
    input  wire logic              chip_select_n,
    input  wire logic              write_enable_n,
    input  wire logic [ADDR_W-2:0] address_in,
    input  wire logic              bank_select_address,
    input  wire logic [LANES-1:0]  byte_write_enable_n,
    input  wire logic [DATA_W-1:0] data_io_lanes_in,
    output logic      [DATA_W-1:0] data_io_lanes_out,
    output logic                   data_io_lanes_oe,
    input  wire logic              output_enable_n,
    input  wire logic              sleep_request,
    input  wire logic              bank_mode_pin
);

    // All control state of the controller.
    typedef struct packed {
        logic              cmd_rd;   // A read was captured at the last edge.
        logic              cmd_wr;   // A write was captured at the last edge.
        logic [ADDR_W-2:0] addr;     // Address captured with the command.
        logic              bank;     // Bank bit captured with the command.
        logic              wb_valid; // The write buffer holds a write.
        logic [ADDR_W-1:0] wb_addr;  // Array address of the buffered write.
        logic [LANES-1:0]  wb_mask;  // Lanes of the buffered write, active high.
        logic [DATA_W-1:0] wb_data;  // Data of the buffered write.
        logic              drive;    // Output drivers wanted by the pipeline.
    } ssl_state_t;

    ssl_state_t st_r;   // Registered state.
    ssl_state_t st_nxt; // Next state.

    logic mode_strap;   // Synchronised level of the mode strap.
    logic bank_mode;    // High while the two-bank scheme is selected.
    logic new_rd;       // A read is sampled at this edge.
    logic new_wr;       // A write is sampled at this edge.
    logic read_bank;    // Bank that supplies the pending read.
    logic [ADDR_W-1:0] read_addr;   // Full array address of the pending read.
    logic [DATA_W-1:0] commit_data; // Data committed from the buffer.

    // The array interface bundle.
    ssl_mem_if #(.AW(ADDR_W), .DW(DATA_W), .LN(LANES)) mbus ();

    // The mode strap is static but arrives from outside the clock domain.
    ssl_sync u_strap (
        .mclk     (mclk),
        .nrst     (nrst),
        .async_in (bank_mode_pin),
        .sync_out (mode_strap)
    );

    // A low strap selects the two-bank scheme, a high one plain addressing.
    assign bank_mode = (mode_strap == ssl_pkg::MODE_BANK_LEVEL);

    // Decodes the command sampled at this rising edge.
    always_comb begin
        // Select high is a deselect; otherwise write enable picks direction.
        new_rd = !chip_select_n && write_enable_n;
        new_wr = !chip_select_n && !write_enable_n;
    end

    // Chooses the bank and full address of a read in flight.
    always_comb begin
        if (bank_mode) begin
            // The bank bit of a read is taken one cycle after its command.
            read_bank = bank_select_address;
        end else begin
            // In plain addressing the pin is an ordinary address bit.
            read_bank = st_r.bank;
        end
        // The bank bit is the top array bit, so each bank is one half.
        read_addr = {read_bank, st_r.addr};
    end

    // The late data of a write is still on the pins when a second write
    // arrives back to back, so the commit takes it from there.
    always_comb begin
        if (st_r.cmd_wr) begin
            commit_data = data_io_lanes_in;
        end else begin
            commit_data = st_r.wb_data;
        end
    end

    // Computes the next pipeline and write-buffer state.
    always_comb begin
        st_nxt = st_r;
        // Input registers take command, address and bank bit at every edge.
        st_nxt.cmd_rd = new_rd;
        st_nxt.cmd_wr = new_wr;
        st_nxt.addr   = address_in;
        // A write takes its bank bit at the command edge in either mode.
        st_nxt.bank   = bank_select_address;
        if (new_wr) begin
            // The new write replaces the buffered one after its commit.
            st_nxt.wb_valid = 1'b1;
            st_nxt.wb_addr  = {bank_select_address, address_in};
            // A lane is written only when its enable was sampled low.
            st_nxt.wb_mask  = ~byte_write_enable_n;
        end
        if (st_r.cmd_wr) begin
            // Write data is taken one full cycle after its command.
            st_nxt.wb_data = data_io_lanes_in;
        end
        // Drivers turn on one cycle after a read and off one after any
        // write or deselect.
        st_nxt.drive = st_r.cmd_rd;
    end

    // Registers the state; reset also clears the buffer contents.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r.cmd_rd   <= ssl_pkg::CTRL_RST;
            st_r.cmd_wr   <= ssl_pkg::CTRL_RST;
            st_r.addr     <= '0;
            st_r.bank     <= ssl_pkg::CTRL_RST;
            st_r.wb_valid <= ssl_pkg::CTRL_RST;
            st_r.wb_addr  <= '0;
            st_r.wb_mask  <= '0;
            st_r.wb_data  <= '0;
            st_r.drive    <= ssl_pkg::CTRL_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Drives the array: commits on each new write while the buffer holds one, reads for each read.
    always_comb begin
        // The buffered write reaches the array only when a newer one arrives.
        mbus.we       = new_wr && st_r.wb_valid;
        mbus.waddr    = st_r.wb_addr;
        mbus.wdata    = commit_data;
        mbus.wmask    = st_r.wb_mask;
        // The read register loads one edge after the read command.
        mbus.re       = st_r.cmd_rd;
        mbus.raddr    = read_addr;
        // A read of the buffered address sees the buffered lanes.
        mbus.hit      = st_r.wb_valid && (st_r.wb_addr == read_addr);
        mbus.byp_data = st_r.wb_data;
        mbus.byp_mask = st_r.wb_mask;
    end

    // The storage array with its registered read port.
    ssl_mem #(
        .AW (ADDR_W),
        .DW (DATA_W),
        .LN (LANES)
    ) u_mem (
        .mclk (mclk),
        .mp   (mbus.mem)
    );

    // Read data come straight from the array's output register.
    assign data_io_lanes_out = mbus.rdata;

    // The drivers follow the pipeline flop, but output enable and sleep cut
    // them at once without waiting for a clock edge.
    assign data_io_lanes_oe = st_r.drive && !output_enable_n
                              && !sleep_request;

endmodule : ssl_top // ssl_top

// File: tb/ssl_chk_checker.sv
// Port-level assertions for the late-write static RAM.
`timescale 1ns/1ps
module ssl_chk #(
    parameter int DATA_W = ssl_pkg::DATA_W,
    parameter int ADDR_W = ssl_pkg::ADDR_W,
    parameter int LANES  = DATA_W / ssl_pkg::LANE_W
) (
    input wire logic              mclk,
    input wire logic              nrst,
    input wire logic              chip_select_n,
    input wire logic              write_enable_n,
    input wire logic [ADDR_W-2:0] address_in,
    input wire logic              bank_select_address,
    input wire logic [LANES-1:0]  byte_write_enable_n,
    input wire logic [DATA_W-1:0] data_io_lanes_in,
    input wire logic [DATA_W-1:0] data_io_lanes_out,
    input wire logic              data_io_lanes_oe,
    input wire logic              output_enable_n,
    input wire logic              sleep_request,
    input wire logic              bank_mode_pin
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire  rd    = !chip_select_n && write_enable_n;    // A read is sampled.
    wire  quiet = output_enable_n || sleep_request;     // Drivers are gated off.
    logic seen_r;                                       // A read has been sampled since reset.
    // Remembers a read since reset, so the hold check never sees an unloaded register.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) seen_r <= 1'b0;
        else if (rd) seen_r <= 1'b1;
    end
    oe_gate_a: assert property (output_enable_n |-> !data_io_lanes_oe)
        else $error("drivers on while output enable high");
    sleep_off_a: assert property (sleep_request |-> !data_io_lanes_oe)
        else $error("drivers on during sleep");
    read_drive_a: assert property (rd |=> ##1 (data_io_lanes_oe || quiet))
        else $error("read data not driven");
    write_release_a: assert property (!rd |=> ##1 !data_io_lanes_oe)
        else $error("pins driven after write or deselect");
    reset_quiet_a: assert property ($rose(nrst) |-> !data_io_lanes_oe)
        else $error("drivers on out of reset");
    // Reads at two edges in a row keep the drivers on for the two following cycles.
    burst_oe_a: assert property (rd ##1 rd |=> (data_io_lanes_oe || quiet) [*2])
        else $error("drivers gap in back-to-back reads");
    out_hold_a: assert property (!rd && seen_r |=> ##1 $stable(data_io_lanes_out))
        else $error("output register changed without a read");
    wr_rd_bypass_a: assert property ((!chip_select_n && !write_enable_n &&
        byte_write_enable_n == '0) ##1 (rd && bank_mode_pin && $stable(address_in) &&
        $stable(bank_select_address)) |=> ##1 data_io_lanes_out == $past(data_io_lanes_in, 2))
        else $error("read missed buffered write");
    cover property (rd ##1 rd);
    cover property ((!chip_select_n && !write_enable_n) ##1 rd);
    cover property (data_io_lanes_oe ##1 sleep_request);
endmodule // ssl_chk
bind ssl_top ssl_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANES(LANES)) u_chk (
    .mclk(mclk), .nrst(nrst), .chip_select_n(chip_select_n),
    .write_enable_n(write_enable_n), .address_in(address_in),
    .bank_select_address(bank_select_address), .byte_write_enable_n(byte_write_enable_n),
    .data_io_lanes_in(data_io_lanes_in), .data_io_lanes_out(data_io_lanes_out),
    .data_io_lanes_oe(data_io_lanes_oe), .output_enable_n(output_enable_n),
    .sleep_request(sleep_request), .bank_mode_pin(bank_mode_pin));

// File: tb/ssl_ctl_model.sv
// Memory controller model: commands, late write data and the late bank bit.
`timescale 1ns/1ps
module ssl_ctl_model (
    input  wire logic        mclk,
    output logic             cs_n,
    output logic             we_n,
    output logic [17:0]      addr,
    output logic             bank,
    output logic [3:0]       bw_n,
    output logic [35:0]      dq,
    output logic             g_n,
    output logic             zz,
    output logic             mode
);
    logic        wr_p   = 1'b0;  // A write still owes its data.
    logic        late_p = 1'b0;  // A bank-mode read still owes its bank bit.
    logic        b_p;            // Owed bank bit.
    logic [35:0] d_p;            // Owed write data.
    // Idle bus; the read-protocol strap starts high, selecting plain addressing.
    initial begin
        {cs_n, we_n, bank, bw_n, dq, g_n, zz, mode} = {2'h3, 1'b0, 4'hf, 36'h0, 2'h0, 1'b1};
        addr = 18'h0;
    end
    // Drives one command and pays what the previous command owes; a released bus inverts.
    task automatic issue(input logic [1:0] op, input logic [17:0] a, input logic b,
                         input logic [3:0] bw, input logic [35:0] d, input logic g,
                         input logic z);
        @(posedge mclk);
        cs_n <= (op == 2'h0);
        we_n <= (op != 2'h2);
        addr <= a;
        bw_n <= bw;
        g_n  <= g;
        zz   <= z;
        dq   <= wr_p ? d_p : ~dq;
        bank <= late_p ? b_p : ((op == 2'h1 && !mode) ? ~b : b);
        wr_p   = (op == 2'h2);
        late_p = (op == 2'h1) && !mode;
        b_p    = b;
        d_p    = d;
    endtask
endmodule // ssl_ctl_model

// File: tb/ssl_top_bench.sv
// Self-checking bench for the late-write static RAM.
`timescale 1ns/1ps
module ssl_top_bench;
    typedef struct packed {
        logic [1:0]  op;  // 0 idle, 1 read, 2 write.
        logic [17:0] a;
        logic        b;
        logic [3:0]  bw;
        logic [35:0] d;   // Write data or expected read data.
        logic        g;
        logic        z;
    } ssl_row_t;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic        cs_n, we_n, bank, oe, g_n, zz, mode;
    logic [17:0] addr;
    logic [3:0]  bw_n;
    logic [35:0] din, dout;
    logic [1:0]  e_v  = 2'h0;    // Reads issued one and two steps ago.
    logic [35:0] e_d [2];        // Their expected data.
    int          fail_count = 0;
    int          n_checks = 0;
    ssl_row_t    rows [24] = '{
        '{2, 5, 0, 0, 36'hfffffffff, 0, 0}, '{1, 5, 0, 0, 36'hfffffffff, 0, 0},
        '{2, 5, 1, 0, 36'h123456789, 0, 0}, '{2, 5, 0, 10, 36'h0, 0, 0},
        '{1, 5, 0, 0, 36'hff803fe00, 0, 0}, '{1, 5, 1, 0, 36'h123456789, 0, 0},
        '{2, 9, 0, 15, 36'h0, 0, 0}, '{1, 5, 0, 0, 36'hff803fe00, 0, 0},
        '{0, 0, 0, 15, 36'h0, 0, 0}, '{0, 0, 0, 15, 36'h0, 0, 0},
        '{2, 3, 0, 0, 36'h0a5a5a5a5, 0, 0}, '{2, 3, 1, 0, 36'h35a5a5a5a, 0, 0},
        '{2, 7, 0, 15, 36'h0, 0, 0}, '{0, 0, 0, 15, 36'h0, 0, 0},
        '{1, 3, 0, 0, 36'h0a5a5a5a5, 0, 0}, '{1, 3, 1, 0, 36'h35a5a5a5a, 0, 0},
        '{0, 0, 0, 15, 36'h0, 0, 0}, '{0, 0, 0, 15, 36'h0, 0, 0},
        '{1, 3, 1, 0, 36'h35a5a5a5a, 0, 0}, '{1, 3, 1, 0, 36'h35a5a5a5a, 0, 0},
        '{1, 3, 1, 0, 36'h35a5a5a5a, 0, 0}, '{0, 0, 0, 15, 36'h0, 1, 0},
        '{0, 0, 0, 15, 36'h0, 0, 1}, '{0, 0, 0, 15, 36'h0, 0, 0}};
    always #12.5 mclk = ~mclk;
    ssl_ctl_model u_ctl (.mclk(mclk), .cs_n(cs_n), .we_n(we_n), .addr(addr), .bank(bank),
        .bw_n(bw_n), .dq(din), .g_n(g_n), .zz(zz), .mode(mode));
    ssl_top u_dut (.mclk(mclk), .nrst(nrst), .chip_select_n(cs_n), .write_enable_n(we_n),
        .address_in(addr), .bank_select_address(bank), .byte_write_enable_n(bw_n),
        .data_io_lanes_in(din), .data_io_lanes_out(dout), .data_io_lanes_oe(oe),
        .output_enable_n(g_n), .sleep_request(zz), .bank_mode_pin(mode));
    // Counts a comparison and reports a mismatch.
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One bus cycle, then checks the read that was issued two cycles earlier.
    task automatic step(input ssl_row_t r);
        u_ctl.issue(r.op, r.a, r.b, r.bw, r.d, r.g, r.z);
        #1;
        chk({35'h0, oe}, {35'h0, e_v[1] & !r.g & !r.z});
        if (e_v[1]) chk(dout, e_d[1]);
        e_v = {e_v[0], r.op == 2'h1};
        e_d[1] = e_d[0];
        e_d[0] = r.d;
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // First ten table rows, then the mode change, the rest of the table, a mid-read reset and array retention.
    initial begin
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        for (int i = 0; i < 10; i++) step(rows[i]);
        @(posedge mclk);
        u_ctl.mode <= 1'b0;
        repeat (32) step(rows[9]);
        for (int i = 10; i < 24; i++) step(rows[i]);
        step(rows[18]);
        step(rows[18]);
        // Idle the bus first so no stale read is sampled right after reset.
        step(rows[9]);
        nrst <= 1'b0;
        #1 chk({35'h0, oe}, 36'h0);
        e_v = 2'h0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) step(rows[9]);
        step(rows[18]);
        repeat (2) step(rows[9]);
        tally_and_finish();
    end
    // The run needs about 74 cycles; this limit is far beyond that.
    initial begin
        #20us;
        fail_count++;
        tally_and_finish();
    end
endmodule // ssl_top_bench
